// ==== common/ubt_cfg.svh ====
// Purpose: Timing, offsets and field positions of the buffered serial unit
// Assumes: core_clk at 250 MHz
// Notes:   Definitions only
`ifndef UBT_CFG_SVH
`define UBT_CFG_SVH

`define UBT_CLK_MHZ       250
`define UBT_BIT_NS        64
`define UBT_BIT_CYC       (((`UBT_BIT_NS * `UBT_CLK_MHZ) + 999) / 1000)
`define UBT_CNT_W         8
`define UBT_BIT_LAST      8'(`UBT_BIT_CYC - 1)
`define UBT_HALF_LAST     8'((`UBT_BIT_CYC / 2) - 1)
`define UBT_DATA_LAST     3'h7

`define UBT_ADDR_TXBUF    4'h0
`define UBT_ADDR_TXSTAT   4'h1
`define UBT_ADDR_RXBUF    4'h2
`define UBT_ADDR_RXERR    4'h3
`define UBT_ADDR_CTRL     4'h4
`define UBT_ADDR_IRQSTAT  4'h5
`define UBT_ADDR_IRQCLR   4'h6
`define UBT_ADDR_IRQEN    4'h7

`define UBT_TXSTAT_BUSY   0
`define UBT_TXSTAT_FULL   1
`define UBT_RXERR_OVR     0
`define UBT_RXERR_FRM     1
`define UBT_CTRL_TXEN     0
`define UBT_CTRL_RXEN     1
`define UBT_CTRL_STOP2    2
`define UBT_IRQ_TXDONE    0
`define UBT_IRQ_RXDONE    1
`define UBT_IRQ_RXERR     2

`define UBT_CTRL_RST      3'h0
`define UBT_IRQ_RST       3'h0
`define UBT_LINE_IDLE     1'b1

`endif

// ==== common/ubt_link_if.sv ====
// Purpose: Two serial lines between the device and its partner
// Assumes: Both lines idle high
// Notes:   No clock; each end samples the other's line itself
`default_nettype none
interface ubt_link_if;
  logic dev_txd;
  logic dev_rxd;
  modport dev (output dev_txd, input dev_rxd);
  modport ptr (input dev_txd, output dev_rxd);
endinterface
`default_nettype wire

// ==== common/ubt_pkg.sv ====
// Purpose: Types shared by both ends of the serial link
// Assumes: ubt_cfg.svh holds the numbers
// Notes:   One-hot state codes
package ubt_pkg;
  typedef enum logic [3:0] {
    UBT_TX_IDLE  = 4'b0001,
    UBT_TX_START = 4'b0010,
    UBT_TX_DATA  = 4'b0100,
    UBT_TX_STOP  = 4'b1000
  } ubt_tx_state_t;

  typedef enum logic [3:0] {
    UBT_RX_IDLE  = 4'b0001,
    UBT_RX_START = 4'b0010,
    UBT_RX_DATA  = 4'b0100,
    UBT_RX_STOP  = 4'b1000
  } ubt_rx_state_t;
endpackage

// ==== sim/uart_buffered_tx_rx_control_tb.sv ====
// Purpose: Register-level test of the device end against the partner end
// Assumes: Both ends share the fixed bit time
// Notes:   Register accesses use the one-cycle strobe port
`default_nettype none
module uart_buffered_tx_rx_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ubt_pkg::*;

  logic       core_clk;
  logic       resetn;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata;
  logic       sw_wr;
  logic       sw_rd;
  logic [7:0] sw_rdata;
  logic       irq;
  logic [7:0] p_tx_data;
  logic       p_tx_valid;
  logic       p_tx_ready;
  logic       p_two_stop;
  logic [7:0] p_rx_data;
  logic       p_rx_valid;
  logic       p_rx_ferr;
  logic [7:0] rxq[$];
  logic [7:0] txb[3] = '{8'ha5, 8'h3c, 8'h81};
  int         err_count = 0;
  int         compares = 0;

  ubt_link_if link_i ();

  ubt_dev_end u_ubt_dev_end (.core_clk(core_clk), .resetn(resetn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .link(link_i));

  ubt_partner_end u_ubt_partner_end (.core_clk(core_clk), .resetn(resetn), .tx_data(p_tx_data),
    .tx_valid(p_tx_valid), .tx_ready(p_tx_ready), .two_stop(p_two_stop), .rx_data(p_rx_data),
    .rx_valid(p_rx_valid), .rx_frame_err(p_rx_ferr), .link(link_i));

  ubt_link_properties u_ubt_link_properties (.core_clk(core_clk), .resetn(resetn), .dev_txd(link_i.dev_txd),
    .dev_rxd(link_i.dev_rxd), .sw_rd(sw_rd), .sw_rdata(sw_rdata));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge core_clk);
    sw_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge core_clk);
    sw_rd   <= 1'b0;
    @(negedge core_clk);
    d = sw_rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    rd(a, d);
    chk(name, d, exp);
  endtask

  task automatic irqchk(input logic v);
    @(negedge core_clk);
    chk("irq", {7'h00, irq}, {7'h00, v});
  endtask

  // Polls a register until the masked bits match, with a bounded count
  task automatic waitreg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] d;
    for (int i = 0; i < 2000; i++) begin
      rd(a, d);
      if ((d & m) === v) break;
    end
    chk("poll", d & m, v);
  endtask

  task automatic ptx(input logic [7:0] d, input logic two);
    @(posedge core_clk);
    p_tx_data  <= d;
    p_two_stop <= two;
    p_tx_valid <= 1'b1;
    // Ready is looked at mid-cycle; the partner takes the byte at the next rising edge
    do @(negedge core_clk); while (p_tx_ready !== 1'b1);
    @(posedge core_clk);
    p_tx_valid <= 1'b0;
  endtask

  always @(negedge core_clk) begin
    if (p_rx_valid === 1'b1) begin
      rxq.push_back(p_rx_data);
      chk("partner frame err", {7'h00, p_rx_ferr}, 8'h00);
    end
  end

  initial begin
    #80000;
    err_count++;
    end_sim();
  end

  initial begin
    resetn = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    p_tx_data = 8'h00;
    p_tx_valid = 1'b0;
    p_two_stop = 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rchk(4'h1, 8'h00, "txstat reset");
    rchk(4'h4, 8'h00, "ctrl reset");
    rchk(4'h8, 8'h00, "unmapped");
    irqchk(1'b0);
    wr(4'h7, 8'h07);
    rchk(4'h7, 8'h07, "irq enable");
    wr(4'h0, 8'hff);
    rchk(4'h1, 8'h00, "txbuf write refused");
    wr(4'h4, 8'h03);
    // Continuous transmit: each later byte waits for buffer-full to clear
    for (int i = 0; i < 3; i++) begin
      if (i > 0) waitreg(4'h1, 8'h02, 8'h00);
      wr(4'h0, txb[i]);
      if (i == 1) rchk(4'h1, 8'h03, "txstat full busy");
    end
    waitreg(4'h1, 8'h03, 8'h00);
    @(posedge core_clk);
    chk("rx count", 8'(rxq.size()), 8'h03);
    for (int i = 0; i < 3; i++) chk("partner byte", rxq[i], txb[i]);
    rchk(4'h5, 8'h01, "tx done status");
    irqchk(1'b1);
    wr(4'h7, 8'h00);
    irqchk(1'b0);
    wr(4'h7, 8'h07);
    irqchk(1'b1);
    wr(4'h6, 8'h01);
    irqchk(1'b0);
    // Two stop bits from the partner; only one is checked
    ptx(8'h5a, 1'b1);
    waitreg(4'h5, 8'h02, 8'h02);
    rchk(4'h3, 8'h00, "rx err two stop");
    rchk(4'h2, 8'h5a, "rx byte");
    rchk(4'h5, 8'h02, "rx done status");
    wr(4'h6, 8'h07);
    // Two frames with no buffer read between them; two stop bits set for transmit only
    wr(4'h4, 8'h07);
    wr(4'h0, 8'hc3);
    ptx(8'h11, 1'b0);
    ptx(8'h22, 1'b0);
    waitreg(4'h5, 8'h04, 8'h04);
    rchk(4'h3, 8'h01, "overrun flag");
    rchk(4'h3, 8'h01, "overrun persists");
    rchk(4'h2, 8'h22, "rx byte after overrun");
    rchk(4'h3, 8'h00, "err after buffer read");
    waitreg(4'h1, 8'h03, 8'h00);
    chk("rx count two stop", 8'(rxq.size()), 8'h04);
    chk("partner byte two stop", rxq[3], 8'hc3);
    irqchk(1'b1);
    end_sim();
  end
endmodule // uart_buffered_tx_rx_control_tb
`default_nettype wire

// ==== sim/ubt_link_properties.sv ====
// Purpose: Concurrent checks on the serial lines and the read port
// Assumes: Single stop bit on transmit; no transmit abort during a check run
// Notes:   Frame counters follow each line from its start bit
`default_nettype none
module ubt_link_properties (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       dev_txd,
  input wire logic       dev_rxd,
  input wire logic       sw_rd,
  input wire logic [7:0] sw_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] tx_cnt_reg;
  logic [7:0] rx_cnt_reg;
  logic       tx_frm_reg;
  logic       rx_frm_reg;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Cycle index within a frame; 160 cycles cover start, 8 data and one stop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_frm_reg <= 1'b0;
      tx_cnt_reg <= 8'h00;
    end else if (tx_frm_reg) begin
      tx_cnt_reg <= tx_cnt_reg + 8'h01;
      tx_frm_reg <= (tx_cnt_reg != 8'h9f);
    end else if (!dev_txd) begin
      tx_frm_reg <= 1'b1;
      tx_cnt_reg <= 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_frm_reg <= 1'b0;
      rx_cnt_reg <= 8'h00;
    end else if (rx_frm_reg) begin
      rx_cnt_reg <= rx_cnt_reg + 8'h01;
      rx_frm_reg <= (rx_cnt_reg != 8'h9f);
    end else if (!dev_rxd) begin
      rx_frm_reg <= 1'b1;
      rx_cnt_reg <= 8'h01;
    end
  end

  sequence s_low_bit(l);
    (!l)[*8] ##1 (!l)[*8];
  endsequence

  a_tx_start_bit: assert property (!tx_frm_reg && !dev_txd |-> s_low_bit(dev_txd))
    else $error("tx start bit not 16 cycles low");
  a_tx_stop_high: assert property (tx_frm_reg && tx_cnt_reg >= 8'h90 |-> dev_txd)
    else $error("tx stop bit not high");
  a_tx_bit_hold: assert property (tx_frm_reg && tx_cnt_reg[3:0] != 4'h0 |-> $stable(dev_txd))
    else $error("tx line moved inside a bit");
  a_rx_start_bit: assert property (!rx_frm_reg && !dev_rxd |-> s_low_bit(dev_rxd))
    else $error("rx start bit not 16 cycles low");
  a_rx_stop_high: assert property (rx_frm_reg && rx_cnt_reg >= 8'h90 |-> dev_rxd)
    else $error("rx stop bit not high");
  a_rx_bit_hold: assert property (rx_frm_reg && rx_cnt_reg[3:0] != 4'h0 |-> $stable(dev_rxd))
    else $error("rx line moved inside a bit");
  a_rdata_one_cycle: assert property (!$past(sw_rd) |-> sw_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule // ubt_link_properties
`default_nettype wire

// ==== verilog/ubt_dev_end.sv ====
// Purpose: Buffered transmit and receive of the async_serial_unit with a software register port
// Assumes: Software follows the polling order below; partner runs at the same bit time
// Notes:   Register read data stand one cycle after the read strobe
// Operation
// - Write next byte only when buffer-full reads 0
// - Show shift busy; reinit only when clear
// - Unread buffer: next frame flags overrun, error persists
// - Receiver checks exactly one stop bit
// - Read error status before receive buffer
// - Transmit rate within partner's tolerance
// - Partner rate within permissible receive range
`include "ubt_cfg.svh"
`default_nettype none
module ubt_dev_end
  import ubt_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic [7:0]      sw_rdata,
  output logic            irq,
  ubt_link_if.dev         link
);
  logic [2:0]             ctrl_reg;
  logic [2:0]             irq_stat_reg;
  logic [2:0]             irq_en_reg;
  logic [7:0]             tx_buffer_reg;
  logic                   tx_full_reg;
  ubt_tx_state_t          tx_state_reg;
  logic [`UBT_CNT_W-1:0]  tx_cnt_reg;
  logic [2:0]             tx_idx_reg;
  logic [7:0]             tx_sh_reg;
  logic                   tx_stop2_reg;
  logic                   txd_reg;
  ubt_rx_state_t          rx_state_reg;
  logic [`UBT_CNT_W-1:0]  rx_cnt_reg;
  logic [2:0]             rx_idx_reg;
  logic [7:0]             rx_sh_reg;
  logic [7:0]             rx_buffer_reg;
  logic                   rx_full_reg;
  logic [1:0]             rx_error_status_reg;
  logic                   rxd_s1_reg;
  logic                   rxd_s2_reg;

  // Address decode
  wire wr_txbuf  = sw_wr & (sw_addr == `UBT_ADDR_TXBUF);
  wire wr_ctrl   = sw_wr & (sw_addr == `UBT_ADDR_CTRL);
  wire wr_irqclr = sw_wr & (sw_addr == `UBT_ADDR_IRQCLR);
  wire wr_irqen  = sw_wr & (sw_addr == `UBT_ADDR_IRQEN);
  wire rd_rxbuf  = sw_rd & (sw_addr == `UBT_ADDR_RXBUF);
  wire tx_en     = ctrl_reg[`UBT_CTRL_TXEN];
  wire rx_en     = ctrl_reg[`UBT_CTRL_RXEN];
  wire tx_tick   = (tx_cnt_reg == '0);
  wire rx_tick   = (rx_cnt_reg == '0);
  wire tx_busy   = (tx_state_reg != UBT_TX_IDLE);
  wire tx_load   = tx_en & ~tx_busy & tx_full_reg;
  wire tx_done   = (tx_state_reg == UBT_TX_STOP) & tx_tick & ~tx_stop2_reg;
  wire rx_end    = rx_en & (rx_state_reg == UBT_RX_STOP) & rx_tick;
  wire frm_err   = rx_end & ~rxd_s2_reg;
  wire ovr_err   = rx_end & rx_full_reg & ~rd_rxbuf;
  wire [2:0] irq_evt = {frm_err | ovr_err, rx_end, tx_done};
  wire [7:0] tx_status = {6'h00, tx_full_reg, tx_busy};
  wire [7:0] rd_mux =
      (sw_addr == `UBT_ADDR_TXSTAT)  ? tx_status :
      (sw_addr == `UBT_ADDR_RXBUF)   ? rx_buffer_reg :
      (sw_addr == `UBT_ADDR_RXERR)   ? {6'h00, rx_error_status_reg} :
      (sw_addr == `UBT_ADDR_CTRL)    ? {5'h00, ctrl_reg} :
      (sw_addr == `UBT_ADDR_IRQSTAT) ? {5'h00, irq_stat_reg} :
      (sw_addr == `UBT_ADDR_IRQEN)   ? {5'h00, irq_en_reg} : 8'h00;

  assign irq = |(irq_stat_reg & irq_en_reg);
  assign link.dev_txd = txd_reg;

  // Register port and sticky interrupt status; a new event wins over its clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg     <= `UBT_CTRL_RST;
      irq_en_reg   <= `UBT_IRQ_RST;
      irq_stat_reg <= `UBT_IRQ_RST;
      sw_rdata     <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= sw_wdata[2:0];
      end
      if (wr_irqen) begin
        irq_en_reg <= sw_wdata[2:0];
      end
      irq_stat_reg <= (irq_stat_reg & ~(wr_irqclr ? sw_wdata[2:0] : 3'h0)) | irq_evt;
      sw_rdata     <= sw_rd ? rd_mux : 8'h00;
    end
  end

  // Transmit buffer: a write while full overwrites the pending byte
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_buffer_reg <= 8'h00;
      tx_full_reg   <= 1'b0;
    end else begin
      if (wr_txbuf & tx_en) begin
        tx_buffer_reg <= sw_wdata;
      end
      tx_full_reg <= tx_en & ((wr_txbuf) | (tx_full_reg & ~tx_load));
    end
  end

  // Transmit shifter; clearing the enable returns it to idle at once
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_reg <= UBT_TX_IDLE;
      tx_cnt_reg   <= '0;
      tx_idx_reg   <= '0;
      tx_sh_reg    <= 8'h00;
      tx_stop2_reg <= 1'b0;
      txd_reg      <= `UBT_LINE_IDLE;
    end else if (!tx_en) begin
      tx_state_reg <= UBT_TX_IDLE;
      tx_cnt_reg   <= '0;
      txd_reg      <= `UBT_LINE_IDLE;
    end else begin
      tx_cnt_reg <= tx_tick ? `UBT_BIT_LAST : tx_cnt_reg - 1'b1;
      case (tx_state_reg)
        UBT_TX_IDLE: begin
          txd_reg <= `UBT_LINE_IDLE;
          if (tx_load) begin
            tx_sh_reg    <= tx_buffer_reg;
            tx_stop2_reg <= ctrl_reg[`UBT_CTRL_STOP2];
            tx_cnt_reg   <= `UBT_BIT_LAST;
            txd_reg      <= 1'b0;
            tx_state_reg <= UBT_TX_START;
          end
        end
        UBT_TX_START: if (tx_tick) begin
          txd_reg      <= tx_sh_reg[0];
          tx_idx_reg   <= '0;
          tx_state_reg <= UBT_TX_DATA;
        end
        UBT_TX_DATA: if (tx_tick) begin
          tx_idx_reg <= tx_idx_reg + 1'b1;
          txd_reg    <= (tx_idx_reg == `UBT_DATA_LAST) ? 1'b1 : tx_sh_reg[tx_idx_reg + 3'h1];
          if (tx_idx_reg == `UBT_DATA_LAST) begin
            tx_state_reg <= UBT_TX_STOP;
          end
        end
        UBT_TX_STOP: if (tx_tick) begin
          if (tx_stop2_reg) begin
            tx_stop2_reg <= 1'b0;
          end else begin
            tx_state_reg <= UBT_TX_IDLE;
          end
        end
        default: tx_state_reg <= UBT_TX_IDLE;
      endcase
    end
  end

  // Receiver; after the single stop sample it hunts for the next start edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxd_s1_reg   <= `UBT_LINE_IDLE;
      rxd_s2_reg   <= `UBT_LINE_IDLE;
      rx_state_reg <= UBT_RX_IDLE;
      rx_cnt_reg   <= '0;
      rx_idx_reg   <= '0;
      rx_sh_reg    <= 8'h00;
    end else begin
      rxd_s1_reg <= link.dev_rxd;
      rxd_s2_reg <= rxd_s1_reg;
      rx_cnt_reg <= rx_tick ? `UBT_BIT_LAST : rx_cnt_reg - 1'b1;
      case (rx_state_reg)
        UBT_RX_IDLE: if (rx_en & ~rxd_s2_reg) begin
          rx_cnt_reg   <= `UBT_HALF_LAST;
          rx_state_reg <= UBT_RX_START;
        end
        UBT_RX_START: if (rx_tick) begin
          rx_idx_reg   <= '0;
          rx_state_reg <= (rxd_s2_reg | ~rx_en) ? UBT_RX_IDLE : UBT_RX_DATA;
        end
        UBT_RX_DATA: if (rx_tick) begin
          rx_sh_reg  <= {rxd_s2_reg, rx_sh_reg[7:1]};
          rx_idx_reg <= rx_idx_reg + 1'b1;
          if (rx_idx_reg == `UBT_DATA_LAST) begin
            rx_state_reg <= UBT_RX_STOP;
          end
        end
        UBT_RX_STOP: if (rx_tick) begin
          rx_state_reg <= UBT_RX_IDLE;
        end
        default: rx_state_reg <= UBT_RX_IDLE;
      endcase
    end
  end

  // Receive buffer and error status; reading the buffer frees it and clears the errors
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_buffer_reg       <= 8'h00;
      rx_full_reg         <= 1'b0;
      rx_error_status_reg <= 2'h0;
    end else begin
      if (rx_end) begin
        rx_buffer_reg <= rx_sh_reg;
      end
      rx_full_reg <= rx_end | (rx_full_reg & ~rd_rxbuf);
      if (rx_end) begin
        rx_error_status_reg <= (rd_rxbuf ? 2'h0 : rx_error_status_reg) | {frm_err, ovr_err};
      end else if (rd_rxbuf) begin
        rx_error_status_reg <= 2'h0;
      end
    end
  end
endmodule // ubt_dev_end
`default_nettype wire

// ==== verilog/ubt_partner_end.sv ====
// Purpose: Remote serial partner, byte in and byte out on a user port
// Assumes: Same bit time as the device
// Notes:   Can send two stop bits; checks one stop bit on reception
`include "ubt_cfg.svh"
`default_nettype none
module ubt_partner_end
  import ubt_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       two_stop,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_frame_err,
  ubt_link_if.ptr         link
);
  ubt_tx_state_t          tx_state_reg;
  logic [`UBT_CNT_W-1:0]  tx_cnt_reg;
  logic [2:0]             tx_idx_reg;
  logic [7:0]             tx_sh_reg;
  logic                   tx_stop2_reg;
  logic                   txd_reg;
  ubt_rx_state_t          rx_state_reg;
  logic [`UBT_CNT_W-1:0]  rx_cnt_reg;
  logic [2:0]             rx_idx_reg;
  logic [7:0]             rx_sh_reg;
  logic                   rxd_s1_reg;
  logic                   rxd_s2_reg;
  wire                    tx_tick = (tx_cnt_reg == '0);
  wire                    rx_tick = (rx_cnt_reg == '0);

  assign tx_ready = (tx_state_reg == UBT_TX_IDLE);
  assign link.dev_rxd = txd_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_reg <= UBT_TX_IDLE;
      tx_cnt_reg   <= '0;
      tx_idx_reg   <= '0;
      tx_sh_reg    <= '0;
      tx_stop2_reg <= 1'b0;
      txd_reg      <= `UBT_LINE_IDLE;
    end else begin
      tx_cnt_reg <= tx_tick ? `UBT_BIT_LAST : tx_cnt_reg - 1'b1;
      case (tx_state_reg)
        UBT_TX_IDLE: begin
          txd_reg <= `UBT_LINE_IDLE;
          if (tx_valid) begin
            tx_sh_reg    <= tx_data;
            tx_stop2_reg <= two_stop;
            tx_cnt_reg   <= `UBT_BIT_LAST;
            txd_reg      <= 1'b0;
            tx_state_reg <= UBT_TX_START;
          end
        end
        UBT_TX_START: if (tx_tick) begin
          txd_reg      <= tx_sh_reg[0];
          tx_idx_reg   <= '0;
          tx_state_reg <= UBT_TX_DATA;
        end
        UBT_TX_DATA: if (tx_tick) begin
          tx_idx_reg <= tx_idx_reg + 1'b1;
          txd_reg    <= (tx_idx_reg == `UBT_DATA_LAST) ? 1'b1 : tx_sh_reg[tx_idx_reg + 3'h1];
          if (tx_idx_reg == `UBT_DATA_LAST) begin
            tx_state_reg <= UBT_TX_STOP;
          end
        end
        UBT_TX_STOP: if (tx_tick) begin
          if (tx_stop2_reg) begin
            tx_stop2_reg <= 1'b0;
          end else begin
            tx_state_reg <= UBT_TX_IDLE;
          end
        end
        default: tx_state_reg <= UBT_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxd_s1_reg   <= `UBT_LINE_IDLE;
      rxd_s2_reg   <= `UBT_LINE_IDLE;
      rx_state_reg <= UBT_RX_IDLE;
      rx_cnt_reg   <= '0;
      rx_idx_reg   <= '0;
      rx_sh_reg    <= '0;
      rx_data      <= '0;
      rx_valid     <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rxd_s1_reg <= link.dev_txd;
      rxd_s2_reg <= rxd_s1_reg;
      rx_valid   <= 1'b0;
      rx_cnt_reg <= rx_tick ? `UBT_BIT_LAST : rx_cnt_reg - 1'b1;
      case (rx_state_reg)
        UBT_RX_IDLE: if (!rxd_s2_reg) begin
          rx_cnt_reg   <= `UBT_HALF_LAST;
          rx_state_reg <= UBT_RX_START;
        end
        UBT_RX_START: if (rx_tick) begin
          rx_idx_reg   <= '0;
          rx_state_reg <= rxd_s2_reg ? UBT_RX_IDLE : UBT_RX_DATA;
        end
        UBT_RX_DATA: if (rx_tick) begin
          rx_sh_reg  <= {rxd_s2_reg, rx_sh_reg[7:1]};
          rx_idx_reg <= rx_idx_reg + 1'b1;
          if (rx_idx_reg == `UBT_DATA_LAST) begin
            rx_state_reg <= UBT_RX_STOP;
          end
        end
        UBT_RX_STOP: if (rx_tick) begin
          rx_data      <= rx_sh_reg;
          rx_valid     <= 1'b1;
          rx_frame_err <= ~rxd_s2_reg;
          rx_state_reg <= UBT_RX_IDLE;
        end
        default: rx_state_reg <= UBT_RX_IDLE;
      endcase
    end
  end
endmodule // ubt_partner_end
`default_nettype wire
